/* File: logic/irs_pkg.sv */
// constants and types shared by both ends of the two-wire register link
// Operation
// - main address 0x48 or 0x40 by option
// - ignore every other slave address
// - test address 0x49 only when unlocked
// - never drive the clock line
// - general call left unacknowledged
// - no device identification query support
// - standard filters at reset and stop
// - master code gets nack, filters high-speed
// - master code slow, speed up after nack
// - high speed survives restart, ends at stop
// - address plus direction bit, ack low
// - first written byte is register pointer
// - commit written byte on next data rise
// - sequential writes to successive registers
// - read after restart from pointer location
// - master ack requests next register
// - master nacks last byte then ends
// - stop leaves pointer unchanged
// - every pointer value is acknowledged
// - nine clocks: eight bits msb first, ack
package irs_pkg;
	localparam logic [6:0] ADDR_MAIN_1 = 7'h48;
	localparam logic [6:0] ADDR_MAIN_0 = 7'h40;
	localparam logic [6:0] ADDR_TEST = 7'h49;
	localparam logic [4:0] HS_PFX = 5'h01;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [3:0] REQ_GAP = 4'hC;
	localparam logic FILT_RST = 1'b0;
	localparam int CLK_NS = 50;
	localparam int F_FM_KHZ = 1000;
	localparam int F_HS_KHZ = 3400;
	localparam int HALF_FM_CYC = (1000000 + 2 * F_FM_KHZ * CLK_NS - 1) / (2 * F_FM_KHZ * CLK_NS);
	localparam int HALF_HS_CYC = (1000000 + 2 * F_HS_KHZ * CLK_NS - 1) / (2 * F_HS_KHZ * CLK_NS);
	localparam logic [3:0] HALF_FM = 4'(HALF_FM_CYC - 1);
	localparam logic [3:0] HALF_HS = 4'(HALF_HS_CYC - 1);
	typedef enum logic [2:0] {
		DS_IDLE = 3'h0,
		DS_ADDR = 3'h1,
		DS_PTR = 3'h3,
		DS_WR = 3'h2,
		DS_RD = 3'h6
	} irs_dst_t;
	typedef enum logic [1:0] {
		MS_IDLE = 2'h0,
		MS_START = 2'h1,
		MS_BIT = 2'h3,
		MS_STOP = 2'h2
	} irs_mst_t;
	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ = 2'h3,
		OP_STOP = 2'h2
	} irs_op_t;
endpackage

/* File: logic/irs_if.sv */
// open-drain two-wire link between master and register slave
`timescale 1ns/10ps
interface irs_if;
	logic scl_oe_n;
	logic sda_m_oe_n;
	logic sda_s_oe_n;
	logic scl;
	logic sda;
	// pull-up wins unless someone pulls low
	assign scl = scl_oe_n;
	assign sda = sda_m_oe_n & sda_s_oe_n;
	modport master(output scl_oe_n, output sda_m_oe_n, input scl, input sda);
	modport slave(output sda_s_oe_n, input scl, input sda);
endinterface

/* File: logic/irs_sync.sv */
// three-stage input synchroniser, output moves when stages two and three agree
`timescale 1ns/10ps
module irs_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RV = '0
) (
	// clock
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_ff <= RV;
			s2_ff <= RV;
			s3_ff <= RV;
			q_ff <= RV;
		end else if (en) begin
			s1_ff <= d;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			for (int i = 0; i < W; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					q_ff[i] <= s3_ff[i];
				end
			end
		end
	end
	assign q = q_ff;
endmodule

/* File: logic/irs_slave.sv */
// register slave end: link side on link_clk, register port on clock
`timescale 1ns/10ps
module irs_slave
	import irs_pkg::*;
(
	// system clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// factory options
	input wire logic addr_opt,
	input wire logic test_unlock,
	// register write port
	output logic reg_wr_stb,
	output logic [7:0] reg_wr_addr,
	output logic [7:0] reg_wr_data,
	// register read port
	output logic reg_rd_stb,
	output logic [7:0] reg_rd_addr,
	input wire logic [7:0] reg_rd_data,
	// filter selection
	output logic filt_hs,
	// link
	input wire logic link_clk,
	irs_if.slave bus
);
	logic [1:0] pin_q;
	logic [2:0] s2l_q;
	logic [1:0] l2s_q;
	logic scl_d_ff;
	logic sda_d_ff;
	irs_dst_t st_ff;
	logic [3:0] bit_ff;
	logic [7:0] rx_ff;
	logic [7:0] tx_ff;
	logic [7:0] ptr_ff;
	logic [7:0] rdata_ff;
	logic sda_oe_n_ff;
	logic mack_ff;
	logic hs_ff;
	logic ackseen_ff;
	logic pend_ff;
	logic [7:0] pend_addr_ff;
	logic [7:0] pend_data_ff;
	logic rdq_ff;
	logic [7:0] rdq_addr_ff;
	logic req_tgl_ff;
	logic req_wr_ff;
	logic [7:0] req_addr_ff;
	logic [7:0] req_data_ff;
	logic scl_f, sda_f, scl_rise, scl_fall, start_c, stop_c, sda_rise;
	logic ack_fall, end_fall, hit, rd_now, set_pend, commit;
	logic [7:0] rd_addr_nxt;
	logic [6:0] main_addr;
	logic seen_ff, wr_stb_ff, rd_stb_ff, rd_cap_ff, ack_tgl_ff, filt_hs_ff;
	logic [7:0] wr_addr_ff, wr_data_ff, rd_addr_ff, rdata_hold_ff;
	logic req_new;
	logic wrq_ff;
	logic [7:0] wrq_addr_ff;
	logic [7:0] wrq_data_ff;
	logic [3:0] gap_ff;

	// link pins and system levels into the link domain
	irs_sync #(.W(2), .RV(2'h3)) u_pin (
		.clk(link_clk),
		.rst(rst),
		.en(1'b1),
		.d({bus.scl, bus.sda}),
		.q(pin_q)
	);
	irs_sync #(.W(3), .RV(3'h0)) u_s2l (
		.clk(link_clk),
		.rst(rst),
		.en(1'b1),
		.d({addr_opt, test_unlock, ack_tgl_ff}),
		.q(s2l_q)
	);

	assign scl_f = pin_q[1];
	assign sda_f = pin_q[0];
	assign scl_rise = scl_f & ~scl_d_ff;
	assign scl_fall = ~scl_f & scl_d_ff;
	assign start_c = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
	assign stop_c = scl_f & scl_d_ff & ~sda_d_ff & sda_f;
	assign sda_rise = sda_f & ~sda_d_ff;
	assign ack_fall = scl_fall & (bit_ff == BIT_ACK);
	assign end_fall = scl_fall & (bit_ff == BIT_END);

	assign main_addr = s2l_q[2] ? ADDR_MAIN_1 : ADDR_MAIN_0;
	// only main or unlocked test address matches
	assign hit = (rx_ff[7:1] == main_addr) | (s2l_q[1] & (rx_ff[7:1] == ADDR_TEST));

	// fetch at address ack, prefetch next at byte start
	assign rd_now = (st_ff == DS_ADDR & hit & rx_ff[0] & (ack_fall | end_fall)) |
		(st_ff == DS_RD & mack_ff & end_fall);
	assign rd_addr_nxt = ack_fall ? ptr_ff : 8'(ptr_ff + 8'h01);
	assign set_pend = end_fall & (st_ff == DS_WR);
	// commit on data rise, or when a newer byte arrives
	assign commit = pend_ff & (sda_rise | set_pend);

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_f;
			sda_d_ff <= sda_f;
		end
	end

	// framing state and bit count
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			st_ff <= DS_IDLE;
			bit_ff <= 4'h0;
		end else if (stop_c) begin
			st_ff <= DS_IDLE;
		end else if (start_c) begin
			st_ff <= DS_ADDR;
			bit_ff <= 4'h0;
		end else if (st_ff != DS_IDLE) begin
			if (scl_rise) begin
				bit_ff <= 4'(bit_ff + 4'h1);
			end
			if (end_fall) begin
				bit_ff <= 4'h0;
				unique case (st_ff)
					DS_ADDR: begin
						// foreign address or master code: wait for start
						if (!hit) begin
							st_ff <= DS_IDLE;
						end else if (rx_ff[0]) begin
							st_ff <= DS_RD;
						end else begin
							// write header is followed by pointer
							st_ff <= DS_PTR;
						end
					end
					DS_PTR: st_ff <= DS_WR;
					DS_WR: st_ff <= DS_WR;
					DS_RD: begin
						if (!mack_ff) begin
							st_ff <= DS_IDLE;
						end
					end
					default: st_ff <= DS_IDLE;
				endcase
			end
		end
	end

	// received and transmitted bytes
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			rx_ff <= 8'h00;
			tx_ff <= 8'h00;
			mack_ff <= 1'b0;
		end else if (st_ff != DS_IDLE && !start_c && !stop_c) begin
			// msb first, ninth bit is acknowledge
			if (scl_rise && bit_ff < BIT_ACK) begin
				rx_ff <= {rx_ff[6:0], sda_f};
			end
			if (scl_rise && bit_ff == BIT_ACK) begin
				mack_ff <= ~sda_f;
			end
			if (end_fall) begin
				tx_ff <= rdata_ff;
			end else if (scl_fall && bit_ff != 4'h0 && bit_ff < BIT_ACK) begin
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
		end
	end

	// data line driver, clock line is never driven
	// slave only pulls the data line
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			sda_oe_n_ff <= 1'b1;
		end else if (start_c || stop_c) begin
			sda_oe_n_ff <= 1'b1;
		end else if (st_ff != DS_IDLE) begin
			if (ack_fall) begin
				// ack address hit, pointer and every write byte
				sda_oe_n_ff <= ~((st_ff == DS_PTR) | (st_ff == DS_WR) | (st_ff == DS_ADDR & hit));
			end else if (end_fall) begin
				// first data bit out after ack
				if ((st_ff == DS_ADDR & hit & rx_ff[0]) | (st_ff == DS_RD & mack_ff)) begin
					sda_oe_n_ff <= rdata_ff[7];
				end else begin
					sda_oe_n_ff <= 1'b1;
				end
			end else if (scl_fall && st_ff == DS_RD && bit_ff != 4'h0 && bit_ff < BIT_ACK) begin
				sda_oe_n_ff <= tx_ff[6];
			end
		end
	end

	// register pointer
	// kept across stop
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			ptr_ff <= PTR_RST;
		end else if (end_fall && st_ff == DS_PTR) begin
			ptr_ff <= rx_ff;
		end else if ((end_fall && st_ff == DS_WR) || (ack_fall && st_ff == DS_RD)) begin
			ptr_ff <= 8'(ptr_ff + 8'h01);
		end
	end

	// filter mode on the link side
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			hs_ff <= FILT_RST;
		end else if (stop_c) begin
			hs_ff <= FILT_RST;
		end else if (ack_fall && st_ff == DS_ADDR && rx_ff[7:3] == HS_PFX) begin
			// master code switches to high speed
			hs_ff <= 1'b1;
		end
	end

	// pending write waits for the data rise
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			pend_ff <= 1'b0;
			pend_addr_ff <= 8'h00;
			pend_data_ff <= 8'h00;
		end else if (set_pend) begin
			pend_ff <= 1'b1;
			pend_addr_ff <= ptr_ff;
			pend_data_ff <= rx_ff;
		end else if (commit) begin
			pend_ff <= 1'b0;
		end
	end

	// requests to the system side, writes first
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			rdq_ff <= 1'b0;
			rdq_addr_ff <= 8'h00;
			wrq_ff <= 1'b0;
			wrq_addr_ff <= 8'h00;
			wrq_data_ff <= 8'h00;
			gap_ff <= 4'h0;
			req_tgl_ff <= 1'b0;
			req_wr_ff <= 1'b0;
			req_addr_ff <= 8'h00;
			req_data_ff <= 8'h00;
		end else begin
			if (gap_ff != 4'h0) begin
				gap_ff <= 4'(gap_ff - 4'h1);
			end
			// toggles spaced so the system side sees each one
			if (gap_ff == 4'h0 && wrq_ff) begin
				wrq_ff <= 1'b0;
				gap_ff <= REQ_GAP;
				req_tgl_ff <= ~req_tgl_ff;
				req_wr_ff <= 1'b1;
				req_addr_ff <= wrq_addr_ff;
				req_data_ff <= wrq_data_ff;
			end else if (gap_ff == 4'h0 && rdq_ff) begin
				rdq_ff <= 1'b0;
				gap_ff <= REQ_GAP;
				req_tgl_ff <= ~req_tgl_ff;
				req_wr_ff <= 1'b0;
				req_addr_ff <= rdq_addr_ff;
			end
			if (commit) begin
				wrq_ff <= 1'b1;
				wrq_addr_ff <= pend_addr_ff;
				wrq_data_ff <= pend_data_ff;
			end
			if (rd_now) begin
				rdq_ff <= 1'b1;
				rdq_addr_ff <= rd_addr_nxt;
			end
		end
	end

	// read data returned from the system side
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			ackseen_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else if (s2l_q[0] != ackseen_ff) begin
			ackseen_ff <= s2l_q[0];
			rdata_ff <= rdata_hold_ff;
		end
	end

	assign bus.sda_s_oe_n = sda_oe_n_ff;

	// system side
	irs_sync #(.W(2), .RV(2'h0)) u_l2s (
		.clk(clock),
		.rst(rst),
		.en(clk_en),
		.d({req_tgl_ff, hs_ff}),
		.q(l2s_q)
	);
	assign req_new = l2s_q[1] ^ seen_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			seen_ff <= 1'b0;
			wr_stb_ff <= 1'b0;
			rd_stb_ff <= 1'b0;
			rd_cap_ff <= 1'b0;
			ack_tgl_ff <= 1'b0;
			filt_hs_ff <= FILT_RST;
			wr_addr_ff <= 8'h00;
			wr_data_ff <= 8'h00;
			rd_addr_ff <= 8'h00;
			rdata_hold_ff <= 8'h00;
		end else if (clk_en) begin
			seen_ff <= l2s_q[1];
			wr_stb_ff <= req_new & req_wr_ff;
			rd_stb_ff <= req_new & ~req_wr_ff;
			rd_cap_ff <= rd_stb_ff;
			filt_hs_ff <= l2s_q[0];
			if (req_new) begin
				wr_addr_ff <= req_addr_ff;
				wr_data_ff <= req_data_ff;
				rd_addr_ff <= req_addr_ff;
			end
			if (rd_cap_ff) begin
				rdata_hold_ff <= reg_rd_data;
				ack_tgl_ff <= ~ack_tgl_ff;
			end
		end
	end

	assign reg_wr_stb = wr_stb_ff;
	assign reg_wr_addr = wr_addr_ff;
	assign reg_wr_data = wr_data_ff;
	assign reg_rd_stb = rd_stb_ff;
	assign reg_rd_addr = rd_addr_ff;
	assign filt_hs = filt_hs_ff;
endmodule

/* File: logic/irs_master.sv */
// bus master end: byte-level command port, clock line made by a divider
`timescale 1ns/10ps
module irs_master
	import irs_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// command
	input wire logic cmd_valid,
	input wire irs_op_t cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ack,
	output logic cmd_ready,
	// response
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack,
	output logic hs_active,
	// link
	irs_if.master bus
);
	logic sda_q;
	irs_mst_t st_ff;
	logic [1:0] step_ff;
	logic [3:0] tmr_ff, bit_ff;
	logic [8:0] sh_ff;
	logic scl_oe_n_ff, sda_oe_n_ff, rdy_ff, rsp_v_ff, nack_ff, hs_ff, first_ff;
	logic [7:0] rsp_d_ff;
	logic take, tick, sample;
	logic [3:0] half;

	irs_sync #(.W(1), .RV(1'b1)) u_sda (
		.clk(clock),
		.rst(rst),
		.en(clk_en),
		.d(bus.sda),
		.q(sda_q)
	);

	assign take = cmd_valid & rdy_ff;
	assign tick = (st_ff != MS_IDLE) & (tmr_ff == 4'h0);
	assign sample = tick & (st_ff == MS_BIT) & (step_ff == 2'h2);
	// slow until the master code is refused
	assign half = hs_ff ? HALF_HS : HALF_FM;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_ff <= MS_IDLE;
			step_ff <= 2'h0;
			tmr_ff <= 4'h0;
			bit_ff <= 4'h0;
			rdy_ff <= 1'b1;
		end else if (clk_en) begin
			if (st_ff == MS_IDLE) begin
				if (take) begin
					rdy_ff <= 1'b0;
					step_ff <= 2'h0;
					bit_ff <= 4'h0;
					unique case (cmd_op)
						OP_START: st_ff <= MS_START;
						OP_STOP: st_ff <= MS_STOP;
						OP_WRITE: st_ff <= MS_BIT;
						OP_READ: st_ff <= MS_BIT;
					endcase
				end
			end else if (!tick) begin
				tmr_ff <= 4'(tmr_ff - 4'h1);
			end else begin
				tmr_ff <= half;
				step_ff <= 2'(step_ff + 2'h1);
				if (sample) begin
					step_ff <= 2'h0;
					bit_ff <= 4'(bit_ff + 4'h1);
					if (bit_ff == BIT_ACK) begin
						st_ff <= MS_IDLE;
						rdy_ff <= 1'b1;
					end
				end else if (step_ff == 2'h3) begin
					st_ff <= MS_IDLE;
					rdy_ff <= 1'b1;
				end
			end
		end
	end

	// pin sequencing per step
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_oe_n_ff <= 1'b1;
			sda_oe_n_ff <= 1'b1;
		end else if (clk_en && tick) begin
			unique case (st_ff)
				MS_START: begin
					case (step_ff)
						2'h0: sda_oe_n_ff <= 1'b1;
						2'h1: scl_oe_n_ff <= 1'b1;
						2'h2: sda_oe_n_ff <= 1'b0;
						default: scl_oe_n_ff <= 1'b0;
					endcase
				end
				MS_STOP: begin
					case (step_ff)
						2'h0: sda_oe_n_ff <= 1'b0;
						2'h1: scl_oe_n_ff <= 1'b1;
						2'h2: sda_oe_n_ff <= 1'b1;
						default: ;
					endcase
				end
				MS_BIT: begin
					// data changes only while clock is low
					case (step_ff)
						2'h0: sda_oe_n_ff <= sh_ff[8];
						2'h1: scl_oe_n_ff <= 1'b1;
						default: scl_oe_n_ff <= 1'b0;
					endcase
				end
				MS_IDLE: ;
			endcase
		end
	end

	// shifting, responses and speed mode
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sh_ff <= 9'h1FF;
			rsp_v_ff <= 1'b0;
			rsp_d_ff <= 8'h00;
			nack_ff <= 1'b0;
			hs_ff <= 1'b0;
			first_ff <= 1'b0;
		end else if (clk_en) begin
			rsp_v_ff <= 1'b0;
			if (take) begin
				unique case (cmd_op)
					OP_START: first_ff <= 1'b1;
					OP_STOP: hs_ff <= 1'b0;
					OP_WRITE: sh_ff <= {cmd_data, 1'b1};
					// ack asks for more, nack ends
					OP_READ: sh_ff <= {8'hFF, ~cmd_ack};
				endcase
			end
			if (sample) begin
				sh_ff <= {sh_ff[7:0], sda_q};
				if (bit_ff == BIT_ACK) begin
					rsp_v_ff <= 1'b1;
					rsp_d_ff <= sh_ff[7:0];
					nack_ff <= sda_q;
					first_ff <= 1'b0;
					if (first_ff && sh_ff[7:3] == HS_PFX && sda_q) begin
						hs_ff <= 1'b1;
					end
				end
			end
		end
	end

	assign bus.scl_oe_n = scl_oe_n_ff;
	assign bus.sda_m_oe_n = sda_oe_n_ff;
	assign cmd_ready = rdy_ff;
	assign rsp_valid = rsp_v_ff;
	assign rsp_data = rsp_d_ff;
	assign rsp_nack = nack_ff;
	assign hs_active = hs_ff;
endmodule

/* File: tb/irs_monitor.sv */
// wire-level checks of the two-wire link between both ends
`timescale 1ns/10ps
module irs_monitor
	import irs_pkg::*;
(
	// link clock and reset
	input wire logic link_clk,
	input wire logic rst,
	// slave options
	input wire logic addr_opt,
	input wire logic test_unlock,
	// link wires
	input wire logic scl_oe_n,
	input wire logic sda_m_oe_n,
	input wire logic sda_s_oe_n,
	input wire logic scl,
	input wire logic sda
);
	logic scl_ff, sda_ff, hdr_ack_ff, ign_ff;
	logic [3:0] bit_ff;
	logic [7:0] sh_ff, hdr_ff, nby_ff;
	logic rise, start, hit, ack9;
	assign rise = scl & ~scl_ff;
	assign start = scl & scl_ff & sda_ff & ~sda;
	assign ack9 = rise & (bit_ff == BIT_ACK);
	assign hit = (sh_ff[7:1] == (addr_opt ? ADDR_MAIN_1 : ADDR_MAIN_0)) | (test_unlock & (sh_ff[7:1] == ADDR_TEST));
	// bit and byte position since the last start
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			{scl_ff, sda_ff} <= 2'h3;
			{bit_ff, nby_ff, ign_ff, sh_ff, hdr_ff, hdr_ack_ff} <= '0;
		end else begin
			{scl_ff, sda_ff} <= {scl, sda};
			if (start) begin
				{bit_ff, nby_ff, ign_ff} <= '0;
			end else if (rise) begin
				bit_ff <= (bit_ff == BIT_END) ? 4'h1 : bit_ff + 4'h1;
				nby_ff <= nby_ff + 8'(bit_ff == BIT_END);
				if (bit_ff != BIT_ACK) sh_ff <= {sh_ff[6:0], sda};
				if (ack9 && nby_ff == 8'h00) begin
					{hdr_ff, hdr_ack_ff, ign_ff} <= {sh_ff, ~sda, sda};
				end
			end
		end
	end
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (rst);
	AST_SDA_HOLD: assert property (scl && scl_ff |-> $stable(sda_s_oe_n))
		else $error("slave data moved while clock high");
	AST_HDR_QUIET: assert property (rise && bit_ff < BIT_ACK && nby_ff == 8'h00 |-> sda_s_oe_n)
		else $error("slave drove data during address byte");
	AST_ADDR_ACK: assert property (ack9 && nby_ff == 8'h00 |-> sda_s_oe_n == !hit)
		else $error("address acknowledge wrong");
	AST_FOREIGN: assert property (ack9 && nby_ff == 8'h00 && !hit |-> sda_s_oe_n)
		else $error("foreign address acknowledged");
	AST_TEST_ADDR: assert property (ack9 && nby_ff == 8'h00 && sh_ff[7:1] == ADDR_TEST |-> sda_s_oe_n == !test_unlock)
		else $error("test address acknowledge wrong");
	AST_GCALL: assert property (ack9 && nby_ff == 8'h00 && sh_ff == 8'h00 |-> sda_s_oe_n)
		else $error("general call acknowledged");
	AST_DEVID: assert property (ack9 && nby_ff == 8'h00 && sh_ff[7:1] == 7'h7C |-> sda_s_oe_n)
		else $error("identification query acknowledged");
	AST_MCODE: assert property (ack9 && nby_ff == 8'h00 && sh_ff[7:3] == HS_PFX |-> sda_s_oe_n)
		else $error("master code acknowledged");
	AST_PTR_ACK: assert property (ack9 && nby_ff != 8'h00 && hdr_ack_ff && !hdr_ff[0] |-> !sda_s_oe_n)
		else $error("written byte not acknowledged");
	AST_RD_REL: assert property (ack9 && nby_ff != 8'h00 && hdr_ack_ff && hdr_ff[0] |-> sda_s_oe_n)
		else $error("slave held data in master acknowledge slot");
	AST_IGNORE: assert property (ign_ff |-> sda_s_oe_n)
		else $error("slave drove data after refused address");
	AST_M_RELEASE: assert property (ack9 && !(nby_ff != 8'h00 && hdr_ack_ff && hdr_ff[0]) |-> sda_m_oe_n)
		else $error("master drove data in slave acknowledge slot");
	AST_CLK_OWNER: assert property (!scl |-> !scl_oe_n)
		else $error("clock line low without master pull");
endmodule

/* File: tb/i2c_register_slave_tb.sv */
// self-checking bench joining master and register slave ends
`timescale 1ns/10ps
module i2c_register_slave_tb
	import irs_pkg::*;
;
	logic clock = 1'b0, link_clk = 1'b0, rst = 1'b1, addr_opt = 1'b1, test_unlock = 1'b0;
	logic cmd_valid = 1'b0, cmd_ack = 1'b0, hit;
	irs_op_t cmd_op = OP_START;
	logic [7:0] cmd_data = 8'h00, reg_rd_data = 8'h00, p;
	logic reg_wr_stb, reg_rd_stb, cmd_ready, rsp_valid, rsp_nack, hs_active, filt_hs;
	logic [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr, rsp_data;
	logic [7:0] regs [256];
	logic [7:0] mdl [256];
	logic [6:0] a;
	logic [6:0] tab [5] = '{ADDR_MAIN_1, ADDR_MAIN_0, ADDR_TEST, 7'h00, 7'h7C};
	logic [8:0] sh9 = 9'h000;
	logic [15:0] w;
	logic [15:0] wq [$];
	int errors = 0, cmp_count = 0, seed = 35241, mptr = 0;
	irs_if bus();
	irs_master i_irs_master (.clock(clock), .rst(rst), .clk_en(1'b1), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_data(cmd_data), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_nack(rsp_nack), .hs_active(hs_active), .bus(bus.master));
	irs_slave i_irs_slave (.clock(clock), .rst(rst), .clk_en(1'b1), .addr_opt(addr_opt), .test_unlock(test_unlock),
		.reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_stb(reg_rd_stb),
		.reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .filt_hs(filt_hs), .link_clk(link_clk), .bus(bus.slave));
	irs_monitor i_irs_monitor (.link_clk(link_clk), .rst(rst), .addr_opt(addr_opt), .test_unlock(test_unlock),
		.scl_oe_n(bus.scl_oe_n), .sda_m_oe_n(bus.sda_m_oe_n), .sda_s_oe_n(bus.sda_s_oe_n), .scl(bus.scl),
		.sda(bus.sda));
	always #25 clock = ~clock;
	initial begin
		#7;
		forever #15 link_clk = ~link_clk;
	end
	// last nine bits seen on the wire
	always @(posedge bus.scl) sh9 <= {sh9[7:0], bus.sda};
	// register file behind the slave
	always @(negedge clock) begin
		if (reg_rd_stb === 1'b1) reg_rd_data <= regs[reg_rd_addr];
		if (reg_wr_stb === 1'b1) begin
			regs[reg_wr_addr] = reg_wr_data;
			w = (wq.size() > 0) ? wq.pop_front() : {~reg_wr_addr, 8'h00};
			chk_byte(reg_wr_addr, w[15:8]);
			chk_byte(reg_wr_data, w[7:0]);
		end
	end
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask
	task automatic wait_rdy();
		for (int n = 0; cmd_ready !== 1'b1; n++) begin
			@(negedge clock);
			if (n > 3000) begin
				errors++;
				$display("wrong value at %0t: command port hung", $time);
				complete_run();
			end
		end
	endtask
	task automatic op(input irs_op_t o, input logic [7:0] d, input logic k);
		wait_rdy();
		cmd_op = o;
		cmd_data = d;
		cmd_ack = k;
		cmd_valid = 1'b1;
		@(negedge clock);
		cmd_valid = 1'b0;
		@(negedge clock);
		wait_rdy();
	endtask
	task automatic wr(input logic [7:0] d, input logic n);
		op(OP_WRITE, d, 1'b0);
		chk_bit(rsp_nack, n);
		chk_bit(rsp_valid, 1'b1);
		chk_byte(sh9[8:1], d);
	endtask
	task automatic wdat(input logic [7:0] d);
		wr(d, 1'b0);
		wq.push_back({8'(mptr), d});
		mdl[mptr] = d;
		mptr = (mptr + 1) & 255;
	endtask
	task automatic rd(input logic k);
		op(OP_READ, 8'h00, k);
		chk_byte(rsp_data, mdl[mptr]);
		chk_byte(sh9[8:1], mdl[mptr]);
		chk_bit(rsp_nack, ~k);
		mptr = (mptr + 1) & 255;
	endtask
	initial begin
		for (int i = 0; i < 256; i++) begin
			regs[i] = 8'($random(seed));
			mdl[i] = regs[i];
		end
		repeat (10) @(negedge clock);
		rst = 1'b0;
		chk_bit(filt_hs, FILT_RST);
		repeat (10) @(negedge clock);
		for (int i = 0; i < 4; i++) begin
			{test_unlock, addr_opt} = 2'(i);
			repeat (20) @(negedge clock);
			for (int j = 0; j < 6; j++) begin
				a = (j == 5) ? 7'($random(seed)) : tab[j];
				hit = (a == (addr_opt ? ADDR_MAIN_1 : ADDR_MAIN_0)) || (test_unlock && a == ADDR_TEST);
				op(OP_START, 8'h00, 1'b0);
				wr({a, 1'b0}, !hit);
				if (!hit) wr(8'(j), 1'b1);
				op(OP_STOP, 8'h00, 1'b0);
				chk_bit(bus.sda & bus.scl, 1'b1);
			end
		end
		$display("address test done");
		{test_unlock, addr_opt} = 2'h1;
		repeat (20) @(negedge clock);
		for (int k = 0; k < 2; k++) begin
			op(OP_START, 8'h00, 1'b0);
			if (k == 1) begin
				wr({HS_PFX, 3'($random(seed))}, 1'b1);
				chk_bit(hs_active, 1'b1);
				op(OP_START, 8'h00, 1'b0);
			end
			p = 8'($random(seed)) & 8'hF8;
			wr({ADDR_MAIN_1, 1'b0}, 1'b0);
			wr(p, 1'b0);
			mptr = p;
			for (int n = 0; n < 3; n++) wdat(8'($random(seed)));
			op(OP_START, 8'h00, 1'b0);
			chk_bit(filt_hs, k[0]);
			op(OP_STOP, 8'h00, 1'b0);
			for (int n = 0; n < 40 && filt_hs !== 1'b0; n++) @(negedge clock);
			chk_bit(filt_hs, 1'b0);
			chk_bit(hs_active, 1'b0);
		end
		$display("write test done");
		op(OP_START, 8'h00, 1'b0);
		wr({ADDR_MAIN_1, 1'b0}, 1'b0);
		wr(p, 1'b0);
		mptr = p;
		op(OP_START, 8'h00, 1'b0);
		wr({ADDR_MAIN_1, 1'b1}, 1'b0);
		rd(1'b1);
		rd(1'b1);
		rd(1'b0);
		op(OP_STOP, 8'h00, 1'b0);
		op(OP_START, 8'h00, 1'b0);
		wr({ADDR_MAIN_1, 1'b1}, 1'b0);
		rd(1'b0);
		op(OP_STOP, 8'h00, 1'b0);
		chk_byte(8'(wq.size()), 8'h00);
		$display("read test done");
		complete_run();
	end
endmodule
